// File: common/egq_defs.vh
// constants for the electronic gear and quadrature output block
`ifndef EGQ_DEFS_VH
`define EGQ_DEFS_VH
// apb register byte offsets
`define EGQ_OFF_CTRL 12'h000
`define EGQ_OFF_NUM 12'h004
`define EGQ_OFF_DEN 12'h008
`define EGQ_OFF_PPR 12'h00C
`define EGQ_OFF_ENC_RES 12'h010
`define EGQ_OFF_STATUS 12'h014
`define EGQ_OFF_MASK 12'h018
`define EGQ_OFF_REF 12'h01C
`define EGQ_OFF_OUT 12'h020
`define EGQ_OFF_POS 12'h024
// control and status bit positions
`define EGQ_CTRL_RESTART 0
`define EGQ_ST_RATIO_ERR 0
`define EGQ_ST_PPR_ERR 1
`define EGQ_ST_OVERSPEED 2
`define EGQ_ST_DONE 3
`define EGQ_ST_BITS 4
// setting limits and reset values
`define EGQ_SET_MAX 32'h4000_0000
`define EGQ_NUM_RST 32'h0000_0004
`define EGQ_DEN_RST 32'h0000_0001
`define EGQ_PPR_RST 32'h0000_0800
`define EGQ_PPR_MIN 32'h0000_0010
`define EGQ_ENC_RES_RST 32'h0010_0000
// ratio limits: num*1000 >= den and num <= den*4000
`define EGQ_RATIO_LO_K 32'h0000_03E8
`define EGQ_RATIO_HI_K 32'h0000_0FA0
// output rate ceiling 1.6 Mpps at 100 MHz clock, in clock cycles per edge
`define EGQ_CLK_MHZ 100
`define EGQ_MAX_KPPS 1600
`define EGQ_MIN_EDGE_CYC ((`EGQ_CLK_MHZ * 1000 + 4 * `EGQ_MAX_KPPS - 1) / (4 * `EGQ_MAX_KPPS))
`endif

// File: design/egq_gear_div.v
// sequential divider: reference times num over den, remainder carried
`timescale 1ns/1ns
`include "egq_defs.vh"
module egq_gear_div
#(
  parameter W = 32
)
(
  input wire pclk,
  input wire presetn,
  input wire clear,
  input wire start,
  input wire signed [W-1:0] ref_units,
  input wire [W-1:0] num,
  input wire [W-1:0] den,
  output reg busy,
  output reg done,
  output reg signed [W-1:0] counts
);
  reg [2*W-1:0] rem_reg;
  reg [2*W-1:0] dvd_reg;
  reg [2*W-1:0] quo_reg;
  reg [6:0] bit_reg;
  reg neg_reg;
  reg [W-1:0] carry_reg;
  wire [W-1:0] mag;
  wire [2*W-1:0] prod;
  wire [2*W-1:0] trial;
  wire last_bit;
  wire [W-1:0] quo_full;
  assign mag = ref_units[W-1] ? (~ref_units + 1'b1) : ref_units;
  assign prod = mag * num;
  assign trial = {rem_reg[2*W-2:0], dvd_reg[2*W-1]};
  // final quotient bit is decided in the same cycle the result is taken
  assign last_bit = trial >= {{W{1'b0}}, den};
  assign quo_full = {quo_reg[W-2:0], last_bit};
  // restoring division, one quotient bit per clock
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rem_reg <= {2*W{1'b0}};
      dvd_reg <= {2*W{1'b0}};
      quo_reg <= {2*W{1'b0}};
      bit_reg <= 7'd0;
      neg_reg <= 1'b0;
      carry_reg <= {W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
      counts <= {W{1'b0}};
    end
    else
    begin
      done <= 1'b0;
      if (clear)
      begin
        carry_reg <= {W{1'b0}};
        busy <= 1'b0;
      end
      else if (start && !busy)
      begin
        // remainder of last step folded in sign kept apart
        dvd_reg <= prod + {{W{1'b0}}, carry_reg};
        neg_reg <= ref_units[W-1];
        rem_reg <= {2*W{1'b0}};
        quo_reg <= {2*W{1'b0}};
        bit_reg <= 7'd0;
        busy <= 1'b1;
      end
      else if (busy)
      begin
        dvd_reg <= {dvd_reg[2*W-2:0], 1'b0};
        if (trial >= {{W{1'b0}}, den})
        begin
          rem_reg <= trial - {{W{1'b0}}, den};
          quo_reg <= {quo_reg[2*W-2:0], 1'b1};
        end
        else
        begin
          rem_reg <= trial;
          quo_reg <= {quo_reg[2*W-2:0], 1'b0};
        end
        bit_reg <= bit_reg + 7'd1;
        if (bit_reg == 7'd63)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
      if (busy && bit_reg == 7'd63)
      begin
        // counts = ref * num / den
        if (neg_reg)
          counts <= ~quo_full + 1'b1;
        else
          counts <= quo_full;
        carry_reg <= last_bit ? trial[W-1:0] - den : trial[W-1:0];
      end
    end
  end
endmodule

// File: design/egq_quad_gen.v
// quadrature a/b and index generator from a divided position count
`timescale 1ns/1ns
`include "egq_defs.vh"
module egq_quad_gen
(
  input wire pclk,
  input wire presetn,
  input wire enable,
  input wire step,
  input wire dir,
  input wire index_hit,
  output reg phase_a,
  output reg phase_b,
  output reg index_out
);
  reg [1:0] state_reg;
  reg idx_arm_reg;
  wire [1:0] state_next;
  // gray walk 00-01-11-10 gives a and b a quarter cycle apart
  assign state_next = dir ? state_reg - 2'd1 : state_reg + 2'd1;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= 2'd0;
      phase_a <= 1'b0;
      phase_b <= 1'b0;
      index_out <= 1'b0;
      idx_arm_reg <= 1'b0;
    end
    else if (!enable)
    begin
      idx_arm_reg <= 1'b0;
      index_out <= 1'b0;
    end
    else if (step)
    begin
      state_reg <= state_next;
      phase_a <= state_next[1];
      phase_b <= state_next[1] ^ state_next[0];
      // index starts only on a rising a, lasts one a high time
      if (idx_arm_reg && state_next[1] && !phase_a && !index_out)
        index_out <= 1'b1;
      else if (!state_next[1])
      begin
        index_out <= 1'b0;
        if (index_out)
          idx_arm_reg <= 1'b0;
      end
      // a new hit wins over the disarm of the previous pulse
      if (index_hit)
        idx_arm_reg <= 1'b1;
    end
  end
endmodule

// File: design/egq_top.v
// electronic gear and divided quadrature feedback, apb slave
// Behaviour
// - host positions are reference units, converted to counts
// - numerator/denominator 1..2^30, default 4/1, on restart
// - counts equal reference times numerator over denominator
// - ratio outside 0.001..4000 flags setting error
// - phases a and b quarter cycle apart
// - a/b pulses per revolution follow setting
// - one index pulse per motor revolution, only when the count reaching position 0 also gives an output edge
// - index pulse width equals phase a width
// - encoder counts divided to output pulses, default 2048
// - overspeed alarm when pulse rate too high
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "egq_defs.vh"
module egq_top
#(
  parameter W = 32
)
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire enc_valid,
  input wire enc_dir,
  output reg signed [W-1:0] pos_ref_counts,
  output reg pos_ref_valid,
  output reg quad_phase_a_out,
  output reg quad_phase_a_out_n,
  output reg quad_phase_b_out,
  output reg quad_phase_b_out_n,
  output reg index_pulse_out,
  output reg index_pulse_out_n,
  output reg irq
);
  // staged settings written by software, live copies taken at restart
  reg [31:0] num_reg;
  reg [31:0] den_reg;
  reg [31:0] ppr_reg;
  reg [31:0] res_reg;
  reg [31:0] num_live_reg;
  reg [31:0] den_live_reg;
  reg [31:0] ppr_live_reg;
  reg [31:0] res_live_reg;
  reg run_reg;
  reg [`EGQ_ST_BITS-1:0] status_reg;
  reg [`EGQ_ST_BITS-1:0] mask_reg;
  reg signed [31:0] ref_reg;
  reg ref_start_reg;
  reg [31:0] enc_pos_reg;
  reg [31:0] acc_reg;
  reg [15:0] gap_reg;
  reg step_reg;
  reg step_dir_reg;
  reg hit_reg;
  reg over_reg;
  wire wr;
  wire rd;
  wire mapped;
  wire ratio_bad;
  wire ppr_bad;
  wire [63:0] num_k;
  wire [63:0] den_k;
  wire [33:0] acc_sum;
  wire [33:0] acc_wrap;
  wire [31:0] gap_load;
  wire [31:0] pos_next;
  wire div_done;
  wire div_busy;
  wire signed [W-1:0] div_counts;
  wire qa;
  wire qb;
  wire qc;
  reg [`EGQ_ST_BITS-1:0] ev;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `EGQ_OFF_POS);
  // ratio window 0.001..4000 checked without division
  assign num_k = num_reg * `EGQ_RATIO_LO_K;
  assign den_k = den_reg * `EGQ_RATIO_HI_K;
  assign ratio_bad = (num_k < {32'h0000_0000, den_reg}) ||
    ({32'h0000_0000, num_reg} > den_k) ||
    num_reg == 32'h0000_0000 || den_reg == 32'h0000_0000 ||
    num_reg > `EGQ_SET_MAX || den_reg > `EGQ_SET_MAX;
  // at most one output edge per encoder count, so 4*ppr <= resolution
  assign ppr_bad = ppr_reg < `EGQ_PPR_MIN ||
    {ppr_reg, 2'b00} > {2'b00, res_reg};
  // pulse divider: add 4*ppr per count, wrap at the encoder resolution
  assign acc_sum = {2'b00, acc_reg} + {ppr_live_reg, 2'b00};
  assign acc_wrap = acc_sum - {2'b00, res_live_reg};
  assign gap_load = `EGQ_MIN_EDGE_CYC - 1;
  assign pos_next = enc_dir ?
    (enc_pos_reg == 32'h0000_0000 ? res_live_reg - 1'b1 : enc_pos_reg - 1'b1) :
    (enc_pos_reg == res_live_reg - 1'b1 ? 32'h0000_0000 : enc_pos_reg + 1'b1);
  // apb slave: single wait-free access, unmapped gives pslverr
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      num_reg <= `EGQ_NUM_RST;
      den_reg <= `EGQ_DEN_RST;
      ppr_reg <= `EGQ_PPR_RST;
      res_reg <= `EGQ_ENC_RES_RST;
      mask_reg <= {`EGQ_ST_BITS{1'b0}};
      ref_reg <= 32'sh0000_0000;
      ref_start_reg <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      ref_start_reg <= 1'b0;
      if (rd && !penable)
      begin
        case (paddr)
          `EGQ_OFF_CTRL: prdata <= {31'd0, run_reg};
          `EGQ_OFF_NUM: prdata <= num_reg;
          `EGQ_OFF_DEN: prdata <= den_reg;
          `EGQ_OFF_PPR: prdata <= ppr_reg;
          `EGQ_OFF_ENC_RES: prdata <= res_reg;
          `EGQ_OFF_STATUS: prdata <= {28'd0, status_reg};
          `EGQ_OFF_MASK: prdata <= {28'd0, mask_reg};
          `EGQ_OFF_REF: prdata <= ref_reg;
          `EGQ_OFF_OUT: prdata <= pos_ref_counts;
          `EGQ_OFF_POS: prdata <= enc_pos_reg;
          default: prdata <= 32'h0000_0000;
        endcase
      end
      if (wr && pready && mapped)
      begin
        case (paddr)
          `EGQ_OFF_NUM: num_reg <= pwdata;
          `EGQ_OFF_DEN: den_reg <= pwdata;
          `EGQ_OFF_PPR: ppr_reg <= pwdata;
          `EGQ_OFF_ENC_RES: res_reg <= pwdata;
          `EGQ_OFF_MASK: mask_reg <= pwdata[`EGQ_ST_BITS-1:0];
          `EGQ_OFF_REF:
          begin
            ref_reg <= pwdata; // reference in units
            ref_start_reg <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
  // restart: settings become live only here
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      num_live_reg <= `EGQ_NUM_RST;
      den_live_reg <= `EGQ_DEN_RST;
      ppr_live_reg <= `EGQ_PPR_RST;
      res_live_reg <= `EGQ_ENC_RES_RST;
      run_reg <= 1'b1;
    end
    else if (wr && pready && paddr == `EGQ_OFF_CTRL &&
      pwdata[`EGQ_CTRL_RESTART])
    begin
      num_live_reg <= num_reg;
      den_live_reg <= den_reg;
      ppr_live_reg <= ppr_reg;
      res_live_reg <= res_reg;
      run_reg <= !ratio_bad && !ppr_bad; // errors hold block stopped
    end
  end
  // divided feedback: one output edge per accumulator wrap
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enc_pos_reg <= 32'h0000_0000;
      acc_reg <= 32'h0000_0000;
      step_reg <= 1'b0;
      step_dir_reg <= 1'b0;
      hit_reg <= 1'b0;
      over_reg <= 1'b0;
      gap_reg <= 16'd0;
    end
    else
    begin
      step_reg <= 1'b0;
      hit_reg <= 1'b0;
      over_reg <= 1'b0;
      if (gap_reg != 16'd0)
        gap_reg <= gap_reg - 16'd1;
      if (enc_valid && run_reg)
      begin
        enc_pos_reg <= pos_next;
        hit_reg <= pos_next == 32'h0000_0000;
        // four edges per output pulse, so ppr*4 edges per rev
        if (acc_sum >= {2'b00, res_live_reg})
        begin
          acc_reg <= acc_wrap[31:0];
          step_reg <= 1'b1;
          step_dir_reg <= enc_dir;
          // a step while the last gap still runs is too fast
          over_reg <= gap_reg != 16'd0;
          gap_reg <= gap_load[15:0];
        end
        else
          acc_reg <= acc_sum[31:0];
      end
    end
  end
  // events: set wins over write-one-to-clear
  always @*
  begin
    ev = {`EGQ_ST_BITS{1'b0}};
    ev[`EGQ_ST_RATIO_ERR] = ratio_bad;
    ev[`EGQ_ST_PPR_ERR] = ppr_bad;
    ev[`EGQ_ST_OVERSPEED] = over_reg;
    ev[`EGQ_ST_DONE] = div_done;
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_reg <= {`EGQ_ST_BITS{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      status_reg <= (status_reg & ~((wr && pready &&
        paddr == `EGQ_OFF_STATUS) ? pwdata[`EGQ_ST_BITS-1:0] :
        {`EGQ_ST_BITS{1'b0}})) | ev;
      irq <= |((status_reg | ev) & mask_reg);
    end
  end
  egq_gear_div #(.W(W)) u_div
  (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!run_reg),
    .start(ref_start_reg && run_reg),
    .ref_units(ref_reg),
    .num(num_live_reg),
    .den(den_live_reg),
    .busy(div_busy),
    .done(div_done),
    .counts(div_counts)
  );
  egq_quad_gen u_quad
  (
    .pclk(pclk),
    .presetn(presetn),
    .enable(run_reg),
    .step(step_reg),
    .dir(step_dir_reg),
    .index_hit(hit_reg),
    .phase_a(qa),
    .phase_b(qb),
    .index_out(qc)
  );
  // registered outputs, true and inverted pair
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_ref_counts <= {W{1'b0}};
      pos_ref_valid <= 1'b0;
      quad_phase_a_out <= 1'b0;
      quad_phase_a_out_n <= 1'b1;
      quad_phase_b_out <= 1'b0;
      quad_phase_b_out_n <= 1'b1;
      index_pulse_out <= 1'b0;
      index_pulse_out_n <= 1'b1;
    end
    else
    begin
      pos_ref_valid <= div_done;
      if (div_done)
        pos_ref_counts <= div_counts;
      quad_phase_a_out <= qa;
      quad_phase_a_out_n <= !qa;
      quad_phase_b_out <= qb;
      quad_phase_b_out_n <= !qb;
      index_pulse_out <= qc;
      index_pulse_out_n <= !qc;
    end
  end
endmodule

// File: verification/egq_chk_sva.sv
// port checker for the gear and quadrature block
`timescale 1ns/1ns
module egq_chk
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire pos_ref_valid,
  input wire quad_phase_a_out,
  input wire quad_phase_a_out_n,
  input wire quad_phase_b_out,
  input wire quad_phase_b_out_n,
  input wire index_pulse_out,
  input wire index_pulse_out_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // inverted lines must never agree with their true lines
  chk_a_pair_inverse: assert property (
    quad_phase_a_out_n != quad_phase_a_out) else $error("a pair equal");
  chk_b_pair_inverse: assert property (
    quad_phase_b_out_n != quad_phase_b_out) else $error("b pair equal");
  chk_c_pair_inverse: assert property (
    index_pulse_out_n != index_pulse_out) else $error("c pair equal");
  // a quarter cycle apart means a and b never move together
  chk_phase_quarter: assert property (
    $changed(quad_phase_a_out) |-> $stable(quad_phase_b_out))
    else $error("a and b moved together");
  // index rides inside one phase a high period
  chk_index_in_a: assert property (
    index_pulse_out |-> quad_phase_a_out) else $error("index outside a");
  chk_index_width: assert property (
    $rose(index_pulse_out) |-> $rose(quad_phase_a_out) ##[1:1000]
    $fell(index_pulse_out) && $fell(quad_phase_a_out))
    else $error("index width differs");
  chk_ref_pulse: assert property (
    pos_ref_valid |=> !pos_ref_valid) else $error("valid too long");
  // bus answers one cycle after setup, for one cycle
  chk_apb_ready: assert property (
    psel && !penable |=> pready ##1 !pready) else $error("pready late");
  chk_apb_unmapped: assert property (
    psel && penable && pready && paddr > 12'h024 |-> pslverr)
    else $error("unmapped not refused");
  cov_ref: cover property (pos_ref_valid);
  cov_index: cover property ($rose(index_pulse_out));
  cov_err: cover property (pslverr);
endmodule

bind egq_top egq_chk egq_chk_inst
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .pos_ref_valid(pos_ref_valid), .quad_phase_a_out(quad_phase_a_out),
  .quad_phase_a_out_n(quad_phase_a_out_n),
  .quad_phase_b_out(quad_phase_b_out),
  .quad_phase_b_out_n(quad_phase_b_out_n),
  .index_pulse_out(index_pulse_out), .index_pulse_out_n(index_pulse_out_n)
);

// File: verification/egq_host_model.sv
// host controller side: counts the quadrature feedback it receives
`timescale 1ns/1ns
module egq_host_model
(
  input wire pclk,
  input wire presetn,
  input wire clear,
  input wire quad_a,
  input wire quad_b,
  input wire index_in,
  output reg [31:0] a_cnt_reg,
  output reg [31:0] b_cnt_reg,
  output reg [31:0] idx_cnt_reg
);
  reg a_reg;
  reg b_reg;
  reg idx_reg;
  // position feedback taken from rising edges of a, b and index
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      a_reg <= 1'b0;
      b_reg <= 1'b0;
      idx_reg <= 1'b0;
      a_cnt_reg <= 32'h0000_0000;
      b_cnt_reg <= 32'h0000_0000;
      idx_cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      a_reg <= quad_a;
      b_reg <= quad_b;
      idx_reg <= index_in;
      if (clear)
      begin
        a_cnt_reg <= 32'h0000_0000;
        b_cnt_reg <= 32'h0000_0000;
        idx_cnt_reg <= 32'h0000_0000;
      end
      else
      begin
        a_cnt_reg <= a_cnt_reg + {31'h0, quad_a & ~a_reg};
        b_cnt_reg <= b_cnt_reg + {31'h0, quad_b & ~b_reg};
        idx_cnt_reg <= idx_cnt_reg + {31'h0, index_in & ~idx_reg};
      end
    end
endmodule

// File: verification/egq_top_bench.sv
// self-checking bench for the gear and quadrature block
`timescale 1ns/1ns
`include "egq_defs.vh"
module egq_top_bench;
  reg pclk, presetn, psel, penable, pwrite, enc_valid, enc_dir, hclr, err;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  wire [31:0] prdata, a_cnt, b_cnt, idx_cnt;
  wire pready, pslverr, vld, irq, qa, qan, qb, qbn, qc, qcn;
  wire signed [31:0] cnt;
  integer fail_count, n_compared;

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  egq_top egq_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enc_valid(enc_valid), .enc_dir(enc_dir), .pos_ref_counts(cnt),
    .pos_ref_valid(vld), .quad_phase_a_out(qa), .quad_phase_a_out_n(qan),
    .quad_phase_b_out(qb), .quad_phase_b_out_n(qbn),
    .index_pulse_out(qc), .index_pulse_out_n(qcn), .irq(irq));
  egq_host_model egq_host_model_inst (.pclk(pclk), .presetn(presetn),
    .clear(hclr), .quad_a(qa), .quad_b(qb), .index_in(qc),
    .a_cnt_reg(a_cnt), .b_cnt_reg(b_cnt), .idx_cnt_reg(idx_cnt));

  task chk(input [31:0] g, input [31:0] e);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  end
  endtask

  // one apb transfer; entered and left just after a rising edge
  task xfer(input w, input [11:0] a, input [31:0] d);
  begin
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge, so a following setup never lands in this time step
    @(posedge pclk);
  end
  endtask

  task wr(input [11:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rdchk(input [11:0] a, input [31:0] e);
  begin
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  end
  endtask

  // write a reference and wait for its scaled result
  task do_ref(input [31:0] v, input [31:0] e);
  begin
    wr(`EGQ_OFF_REF, v);
    while (vld !== 1'b1) @(posedge pclk);
    chk(cnt, e);
    @(posedge pclk);
  end
  endtask

  // encoder steps spaced gap cycles apart
  task step(input integer n, input integer gap);
  begin
    repeat (n)
    begin
      enc_valid <= 1'b1;
      @(posedge pclk);
      enc_valid <= 1'b0;
      repeat (gap - 1) @(posedge pclk);
    end
  end
  endtask

  task restart(input [31:0] n, input [31:0] d);
  begin
    wr(`EGQ_OFF_NUM, n);
    wr(`EGQ_OFF_DEN, d);
    wr(`EGQ_OFF_CTRL, 32'h0000_0001);
    wr(`EGQ_OFF_STATUS, 32'h0000_000F);
  end
  endtask

  task t_regs;
  begin
    rdchk(`EGQ_OFF_NUM, `EGQ_NUM_RST);
    rdchk(`EGQ_OFF_DEN, `EGQ_DEN_RST);
    rdchk(`EGQ_OFF_PPR, `EGQ_PPR_RST);
    rdchk(`EGQ_OFF_ENC_RES, `EGQ_ENC_RES_RST);
    rdchk(12'h028, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    $display("register test done");
  end
  endtask

  task t_gear;
  begin
    do_ref(32'h0000_000A, 32'h0000_0028);
    wr(`EGQ_OFF_NUM, 32'h0000_0003);
    wr(`EGQ_OFF_DEN, 32'h0000_0002);
    do_ref(32'h0000_0001, 32'h0000_0004);
    wr(`EGQ_OFF_CTRL, 32'h0000_0001);
    do_ref(32'h0000_0001, 32'h0000_0001);
    do_ref(32'h0000_0001, 32'h0000_0002);
    $display("gear test done");
  end
  endtask

  task t_ratio;
  begin
    restart(32'h0000_0001, 32'h0000_03E9);
    rdchk(`EGQ_OFF_STATUS, 32'h0000_0001);
    restart(32'h0000_0001, 32'h0000_03E8);
    rdchk(`EGQ_OFF_STATUS, 32'h0000_0000);
    restart(32'h0000_0FA1, 32'h0000_0001);
    rdchk(`EGQ_OFF_STATUS, 32'h0000_0001);
    restart(32'h0000_0FA0, 32'h0000_0001);
    rdchk(`EGQ_OFF_STATUS, 32'h0000_0000);
    $display("ratio test done");
  end
  endtask

  task t_irq;
  begin
    wr(`EGQ_OFF_MASK, 32'h0000_0008);
    do_ref(32'h0000_0001, 32'h0000_0FA0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`EGQ_OFF_STATUS, 32'h0000_0008);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`EGQ_OFF_MASK, 32'h0000_0000);
    do_ref(32'h0000_0001, 32'h0000_0FA0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("interrupt test done");
  end
  endtask

  // 64 counts per turn, 16 pulses out: one output edge per count
  task t_quad;
  begin
    wr(`EGQ_OFF_ENC_RES, 32'h0000_0040);
    wr(`EGQ_OFF_PPR, 32'h0000_0010);
    restart(32'h0000_0004, 32'h0000_0001);
    step(64, 20);
    hclr <= 1'b1;
    @(posedge pclk);
    hclr <= 1'b0;
    step(64, 20);
    repeat (20) @(posedge pclk);
    chk(a_cnt, 32'h0000_0010);
    chk(b_cnt, 32'h0000_0010);
    chk(idx_cnt, 32'h0000_0001);
    rdchk(`EGQ_OFF_STATUS, 32'h0000_0000);
    step(8, 2);
    xfer(1'b0, `EGQ_OFF_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0004, 32'h0000_0004);
    // one reverse turn: same pulse and index counts
    enc_dir <= 1'b1;
    hclr <= 1'b1;
    @(posedge pclk);
    hclr <= 1'b0;
    step(64, 20);
    repeat (20) @(posedge pclk);
    chk(a_cnt, 32'h0000_0010);
    chk(b_cnt, 32'h0000_0010);
    chk(idx_cnt, 32'h0000_0001);
    $display("quadrature test done");
  end
  endtask

  task report_and_stop;
  begin
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask

  // watchdog well past the expected few thousand cycles
  initial
  begin
    #600000;
    fail_count = fail_count + 1;
    report_and_stop;
  end

  initial
  begin
    fail_count = 0;
    n_compared = 0;
    {presetn, psel, penable, pwrite, enc_valid, enc_dir, hclr} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_gear;
    t_ratio;
    t_irq;
    t_quad;
    report_and_stop;
  end
endmodule
